// [crypto_vector_reg_move_pkg.sv]
// Package of constants and types for the register move instruction unit.
`default_nettype none
package crypto_vector_reg_move_pkg;
	// ****************************************************************
	// Instruction word layout
	// ****************************************************************
	localparam int          DATA_W         = 14;
	localparam int          SIZE_W         = 12;
	localparam int          WORD_W         = 32;
	localparam int          INDEX_W        = 4;
	localparam int          NUM_REGS       = 16;
	localparam logic [1:0]  SET_REG_OP     = 2'h2;
	localparam logic [7:0]  REGISTER_COPY_OP = 8'h02;
	localparam logic [7:0]  STACK_LOAD_OP  = 8'h00;
	localparam int          SHORT_OP_MSB   = 31;
	localparam int          SHORT_OP_LSB   = 30;
	localparam int          OP_MSB         = 31;
	localparam int          OP_LSB         = 24;
	localparam int          COND_MSB       = 23;
	localparam int          COND_LSB       = 20;
	localparam int          SET_DST_MSB    = 29;
	localparam int          SET_DST_LSB    = 26;
	localparam int          DATA_IMM_MSB   = 25;
	localparam int          DATA_IMM_LSB   = 12;
	localparam int          SIZE_IMM_MSB   = 11;
	localparam int          SIZE_IMM_LSB   = 0;
	localparam int          DST_MSB        = 15;
	localparam int          DST_LSB        = 12;
	localparam int          SRC_MSB        = 3;
	localparam int          SRC_LSB        = 0;
	localparam int          WORD_DATA_SHIFT = 16;
	localparam logic [3:0]  STACK_PTR_INDEX = 4'hF;
	// ****************************************************************
	// Condition codes
	// ****************************************************************
	localparam logic [3:0]  COND_ALWAYS    = 4'h0;
	localparam logic [3:0]  COND_ZERO      = 4'h1;
	localparam logic [3:0]  COND_NOT_ZERO  = 4'h2;
	localparam logic [3:0]  COND_CARRY     = 4'h3;
	localparam logic [3:0]  COND_NO_CARRY  = 4'h4;
	localparam logic [3:0]  COND_HIGHER    = 4'h5;
	localparam logic [3:0]  COND_LOWER_EQ  = 4'h6;
	localparam logic [3:0]  COND_EVEN      = 4'h7;
	localparam logic [3:0]  COND_ODD       = 4'h8;
	localparam logic [3:0]  COND_ONE       = 4'h9;
	localparam logic [3:0]  COND_NOT_ONE   = 4'hA;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [SIZE_W-1:0] size;
	} vreg_t;
	typedef struct packed {
		logic carry;
		logic even;
		logic zero;
		logic one;
	} status_t;
	typedef enum logic {
		idle_s,
		wait_mem_s
	} fsm_t;
	typedef struct packed {
		fsm_t                       fsm;
		vreg_t [NUM_REGS-1:0]       regs;
		logic                       ready;
		logic                       mem_req;
		logic [DATA_W-1:0]          mem_addr;
		logic [INDEX_W-1:0]         target;
		logic                       wr_valid;
		logic [INDEX_W-1:0]         wr_index;
		vreg_t                      wr_value;
	} state_t;
endpackage
`default_nettype wire

// [crypto_vector_reg_move_ops.sv]
// Decode and execute logic for the register move instructions.
//
// Contract
// - Load-immediate: top two bits 0x2, unconditional.
// - Load-immediate fields: index, data and size.
// - Load-immediate writes data and size fields.
// - Register copy: opcode 0x02, cc, dst, src.
// - True condition copies data and size fields.
// - Stack load reads word at stack plus offset.
// - Loaded word: high to data, low to size.
// - False condition: no execution, status unchanged.
// - Register data field is always fourteen bits.
`timescale 1ns/10ps
`default_nettype none
module crypto_vector_reg_move_ops (
	input  wire logic                                            ref_clk_i,
	input  wire logic                                            rst_n_i,
	input  wire logic                                            instr_valid_i,
	input  wire logic [crypto_vector_reg_move_pkg::WORD_W-1:0]   instruction_word_i,
	output logic                                                 instr_ready_o,
	input  wire crypto_vector_reg_move_pkg::status_t             status_i,
	output logic                                                 read_buffer_req_o,
	output logic [crypto_vector_reg_move_pkg::DATA_W-1:0]        read_buffer_addr_o,
	input  wire logic                                            read_buffer_valid_i,
	input  wire logic [crypto_vector_reg_move_pkg::WORD_W-1:0]   read_buffer_word_i,
	output logic                                                 wr_valid_o,
	output logic [crypto_vector_reg_move_pkg::INDEX_W-1:0]       wr_index_o,
	output crypto_vector_reg_move_pkg::vreg_t                    wr_value_o
);
	// ****************************************************************
	// Condition evaluation
	// ****************************************************************
	function automatic logic cond_true(input logic [3:0] condition_code,
	                                   input crypto_vector_reg_move_pkg::status_t st);
		logic r;
		r = 1'b0;
		unique case (condition_code)
			crypto_vector_reg_move_pkg::COND_ALWAYS:   r = 1'b1;
			crypto_vector_reg_move_pkg::COND_ZERO:     r = st.zero;
			crypto_vector_reg_move_pkg::COND_NOT_ZERO: r = !st.zero;
			crypto_vector_reg_move_pkg::COND_CARRY:    r = st.carry;
			crypto_vector_reg_move_pkg::COND_NO_CARRY: r = !st.carry;
			crypto_vector_reg_move_pkg::COND_HIGHER:   r = st.carry && !st.zero;
			crypto_vector_reg_move_pkg::COND_LOWER_EQ: r = !st.carry || st.zero;
			crypto_vector_reg_move_pkg::COND_EVEN:     r = st.even;
			crypto_vector_reg_move_pkg::COND_ODD:      r = !st.even;
			crypto_vector_reg_move_pkg::COND_ONE:      r = st.one;
			crypto_vector_reg_move_pkg::COND_NOT_ONE:  r = !st.one;
			default:                                   r = 1'b0;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	crypto_vector_reg_move_pkg::state_t state_reg;
	crypto_vector_reg_move_pkg::state_t state_next;

	logic                                                 taken;
	logic                                                 is_set;
	logic                                                 is_copy;
	logic                                                 is_load;
	logic                                                 cond_ok;
	logic [3:0]                                           condition_code;
	logic [crypto_vector_reg_move_pkg::INDEX_W-1:0]       dst_index;
	logic [crypto_vector_reg_move_pkg::INDEX_W-1:0]       src_index;
	logic [crypto_vector_reg_move_pkg::INDEX_W-1:0]       set_index;
	logic [crypto_vector_reg_move_pkg::DATA_W-1:0]        data_immediate;
	logic [crypto_vector_reg_move_pkg::SIZE_W-1:0]        size_immediate;
	logic [crypto_vector_reg_move_pkg::DATA_W-1:0]        load_addr;
	crypto_vector_reg_move_pkg::vreg_t                    loaded_value;

	assign taken          = instr_valid_i && state_reg.ready;
	assign is_set         = instruction_word_i[crypto_vector_reg_move_pkg::SHORT_OP_MSB:
	                        crypto_vector_reg_move_pkg::SHORT_OP_LSB] ==
	                        crypto_vector_reg_move_pkg::SET_REG_OP;
	assign is_copy        = !is_set && instruction_word_i[crypto_vector_reg_move_pkg::OP_MSB:
	                        crypto_vector_reg_move_pkg::OP_LSB] ==
	                        crypto_vector_reg_move_pkg::REGISTER_COPY_OP;
	assign is_load        = !is_set && instruction_word_i[crypto_vector_reg_move_pkg::OP_MSB:
	                        crypto_vector_reg_move_pkg::OP_LSB] ==
	                        crypto_vector_reg_move_pkg::STACK_LOAD_OP;
	assign condition_code = instruction_word_i[crypto_vector_reg_move_pkg::COND_MSB:
	                        crypto_vector_reg_move_pkg::COND_LSB];
	assign cond_ok        = cond_true(condition_code, status_i);
	assign dst_index      = instruction_word_i[crypto_vector_reg_move_pkg::DST_MSB:
	                        crypto_vector_reg_move_pkg::DST_LSB];
	assign src_index      = instruction_word_i[crypto_vector_reg_move_pkg::SRC_MSB:
	                        crypto_vector_reg_move_pkg::SRC_LSB];
	assign set_index      = instruction_word_i[crypto_vector_reg_move_pkg::SET_DST_MSB:
	                        crypto_vector_reg_move_pkg::SET_DST_LSB];
	assign data_immediate = instruction_word_i[crypto_vector_reg_move_pkg::DATA_IMM_MSB:
	                        crypto_vector_reg_move_pkg::DATA_IMM_LSB];
	assign size_immediate = instruction_word_i[crypto_vector_reg_move_pkg::SIZE_IMM_MSB:
	                        crypto_vector_reg_move_pkg::SIZE_IMM_LSB];
	assign load_addr      = crypto_vector_reg_move_pkg::DATA_W'(
	                        state_reg.regs[crypto_vector_reg_move_pkg::STACK_PTR_INDEX].data +
	                        state_reg.regs[src_index].data);
	assign loaded_value   = {crypto_vector_reg_move_pkg::DATA_W'(read_buffer_word_i >>
	                        crypto_vector_reg_move_pkg::WORD_DATA_SHIFT),
	                        read_buffer_word_i[crypto_vector_reg_move_pkg::SIZE_W-1:0]};

	// ****************************************************************
	// Execute
	// ****************************************************************
	always_comb begin
		state_next          = state_reg;
		state_next.mem_req  = 1'b0;
		state_next.wr_valid = 1'b0;
		unique case (state_reg.fsm)
			crypto_vector_reg_move_pkg::idle_s: begin
				if (taken && is_set) begin
					state_next.regs[set_index].data = data_immediate;
					state_next.regs[set_index].size = size_immediate;
					state_next.wr_valid = 1'b1;
					state_next.wr_index = set_index;
					state_next.wr_value = {data_immediate, size_immediate};
				end else if (taken && is_copy && cond_ok) begin
					state_next.regs[dst_index] = state_reg.regs[src_index];
					state_next.wr_valid = 1'b1;
					state_next.wr_index = dst_index;
					state_next.wr_value = state_reg.regs[src_index];
				end else if (taken && is_load && cond_ok) begin
					state_next.fsm      = crypto_vector_reg_move_pkg::wait_mem_s;
					state_next.ready    = 1'b0;
					state_next.mem_req  = 1'b1;
					state_next.mem_addr = load_addr;
					state_next.target   = dst_index;
				end
				// A false condition or an unknown opcode is consumed with no effect.
			end
			crypto_vector_reg_move_pkg::wait_mem_s: begin
				if (read_buffer_valid_i) begin
					state_next.regs[state_reg.target] = loaded_value;
					state_next.fsm      = crypto_vector_reg_move_pkg::idle_s;
					state_next.ready    = 1'b1;
					state_next.wr_valid = 1'b1;
					state_next.wr_index = state_reg.target;
					state_next.wr_value = loaded_value;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg       <= '0;
			state_reg.fsm   <= crypto_vector_reg_move_pkg::idle_s;
			state_reg.ready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign instr_ready_o      = state_reg.ready;
	assign read_buffer_req_o  = state_reg.mem_req;
	assign read_buffer_addr_o = state_reg.mem_addr;
	assign wr_valid_o         = state_reg.wr_valid;
	assign wr_index_o         = state_reg.wr_index;
	assign wr_value_o         = state_reg.wr_value;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence load_issue_s;
		taken && is_load && !is_set && cond_ok;
	endsequence
	sequence load_done_s;
		state_reg.fsm == crypto_vector_reg_move_pkg::wait_mem_s && read_buffer_valid_i;
	endsequence
	sequence load_wait_s;
		state_reg.fsm == crypto_vector_reg_move_pkg::wait_mem_s && !read_buffer_valid_i;
	endsequence

	set_reg_write_a: assert property (taken && is_set |=> wr_valid_o &&
		wr_value_o == {$past(data_immediate), $past(size_immediate)})
		else $error("load-immediate did not write its immediates");
	set_reg_index_a: assert property (taken && is_set |=> wr_index_o == $past(set_index) &&
		state_reg.regs[wr_index_o].data ==
		$past(instruction_word_i[crypto_vector_reg_move_pkg::DATA_IMM_MSB:crypto_vector_reg_move_pkg::DATA_IMM_LSB]))
		else $error("load-immediate wrote the wrong register");
	copy_index_a: assert property (taken && is_copy && cond_ok |=> wr_valid_o &&
		wr_index_o == $past(instruction_word_i[crypto_vector_reg_move_pkg::DST_MSB:crypto_vector_reg_move_pkg::DST_LSB]))
		else $error("register copy used the wrong destination");
	copy_value_a: assert property (taken && is_copy && cond_ok |=>
		state_reg.regs[$past(dst_index)] == $past(state_reg.regs[src_index]))
		else $error("register copy did not copy data and size");
	load_request_a: assert property (load_issue_s |=> read_buffer_req_o && !instr_ready_o &&
		read_buffer_addr_o == $past(load_addr))
		else $error("stack load did not request the right word");
	load_write_a: assert property (load_done_s |=> wr_valid_o && instr_ready_o &&
		wr_value_o.data == $past(read_buffer_word_i[29:16]) &&
		wr_value_o.size == $past(read_buffer_word_i[11:0]))
		else $error("stack load unpacked the word wrongly");
	false_cond_a: assert property (taken && !is_set && (is_copy || is_load) && !cond_ok |=>
		!wr_valid_o && !read_buffer_req_o && instr_ready_o)
		else $error("instruction with false condition was executed");
	regs_stable_a: assert property (!state_next.wr_valid |=> $stable(state_reg.regs))
		else $error("register file changed without a write");
	set_uncond_a: assert property (taken && is_set && !cond_ok |=> wr_valid_o)
		else $error("load-immediate was skipped on a false condition");
	set_ready_a: assert property (taken && (is_set || is_copy) |=> instr_ready_o)
		else $error("register-only instruction stalled the unit");
	copy_write_a: assert property (taken && is_copy && cond_ok |=> wr_value_o == $past(state_reg.regs[src_index]))
		else $error("register copy reported the wrong value");
	req_pulse_a: assert property (read_buffer_req_o |=> !read_buffer_req_o)
		else $error("buffer read request lasted more than one cycle");
	wait_ready_a: assert property (state_reg.fsm == crypto_vector_reg_move_pkg::wait_mem_s |-> !instr_ready_o)
		else $error("unit accepted an instruction while a load waits");
	load_hold_a: assert property (load_wait_s |=> !wr_valid_o && !instr_ready_o && $stable(state_reg.regs))
		else $error("stack load wrote before its word arrived");
	write_match_a: assert property (wr_valid_o |-> state_reg.regs[wr_index_o] == wr_value_o)
		else $error("reported write differs from the register file");
	unknown_op_a: assert property (taken && !is_set && !is_copy && !is_load |=>
		!wr_valid_o && !read_buffer_req_o && instr_ready_o)
		else $error("unknown opcode had an effect");
endmodule // crypto_vector_reg_move_ops
`default_nettype wire

// [read_buffer_model.sv]
// Behavioural memory buffer that answers read requests after a chosen delay.
`timescale 1ns/10ps
`default_nettype none
module read_buffer_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req_i,
	input  wire logic [3:0]  delay_i,
	input  wire logic [31:0] fill_word_i,
	output logic             valid_o,
	output logic [31:0]      word_o
);
	logic        busy_reg;
	logic [3:0]  cnt_reg;
	logic [31:0] junk_reg;
	// ****************************************************************
	// Delayed answer
	// ****************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
			cnt_reg  <= 4'h0;
			valid_o  <= 1'b0;
			junk_reg <= 32'hA5C3_5A3C;
		end else begin
			junk_reg <= {junk_reg[30:0], ~junk_reg[31]};
			valid_o  <= 1'b0;
			if (req_i) begin
				busy_reg <= 1'b1;
				cnt_reg  <= delay_i;
			end else if (busy_reg && cnt_reg == 4'h0) begin
				valid_o  <= 1'b1;
				busy_reg <= 1'b0;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
	// The word is only meaningful with valid; otherwise it keeps changing.
	assign word_o = valid_o ? fill_word_i : junk_reg;
endmodule // read_buffer_model
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the register move instruction unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                                    ref_clk_i, rst_n_i, instr_valid_i, instr_ready_o, req, vld, wr_valid_o;
	logic [31:0]                             iw, rword, fill_word, seed, r;
	logic [3:0]                              delay, wr_index_o;
	logic [13:0]                             addr;
	crypto_vector_reg_move_pkg::status_t     st;
	crypto_vector_reg_move_pkg::vreg_t       wr_value_o;
	crypto_vector_reg_move_pkg::vreg_t       rf [16];
	int                                      n_errors, comparisons, cycles;
	crypto_vector_reg_move_ops uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
		.instruction_word_i(iw), .instr_ready_o(instr_ready_o), .status_i(st), .read_buffer_req_o(req),
		.read_buffer_addr_o(addr), .read_buffer_valid_i(vld), .read_buffer_word_i(rword),
		.wr_valid_o(wr_valid_o), .wr_index_o(wr_index_o), .wr_value_o(wr_value_o));
	read_buffer_model mem (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req), .delay_i(delay),
		.fill_word_i(fill_word), .valid_o(vld), .word_o(rword));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic cond_holds(input logic [3:0] c, input crypto_vector_reg_move_pkg::status_t s);
		case (c)
			4'h0: return 1'b1;
			4'h1: return s.zero;
			4'h2: return !s.zero;
			4'h3: return s.carry;
			4'h4: return !s.carry;
			4'h5: return s.carry && !s.zero;
			4'h6: return !s.carry || s.zero;
			4'h7: return s.even;
			4'h8: return !s.even;
			4'h9: return s.one;
			4'hA: return !s.one;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Issues one instruction and checks what the unit writes back.
	task automatic exec(input logic [31:0] w);
		logic                              do_it, ld;
		logic [3:0]                        d;
		crypto_vector_reg_move_pkg::vreg_t v;
		logic [13:0]                       a;
		int                                n;
		@(posedge ref_clk_i);
		#1;
		r = rnd();
		st = r[3:0];
		delay = r[7:4];
		fill_word = rnd();
		ld = 1'b0;
		do_it = 1'b1;
		d = w[15:12];
		v = rf[w[3:0]];
		a = rf[15].data + rf[w[3:0]].data;
		if (w[31:30] == 2'h2) begin
			d = w[29:26];
			v = {w[25:12], w[11:0]};
		end else if (w[31:24] == 8'h02) do_it = cond_holds(w[23:20], st);
		else if (w[31:24] == 8'h00) begin
			do_it = cond_holds(w[23:20], st);
			ld = do_it;
		end else do_it = 1'b0;
		chk(32'(instr_ready_o), 32'h1);
		instr_valid_i = 1'b1;
		iw = w;
		@(posedge ref_clk_i);
		#1;
		instr_valid_i = 1'b0;
		if (ld) begin
			chk(32'({req, instr_ready_o}), 32'h2);
			chk(32'(addr), 32'(a));
			n = 0;
			while (wr_valid_o !== 1'b1 && n < 40) begin
				@(posedge ref_clk_i);
				#1;
				n++;
			end
			v = {fill_word[29:16], fill_word[11:0]};
		end
		chk(32'(wr_valid_o), 32'(do_it));
		if (do_it) begin
			chk(32'(wr_index_o), 32'(d));
			chk(32'(wr_value_o), 32'(v));
			rf[d] = v;
		end
	endtask
	// ****************************************************************
	// Clock, timeout and sequence
	// ****************************************************************
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		{rst_n_i, instr_valid_i, iw, fill_word, delay, st} = '0;
		{n_errors, comparisons, cycles} = '0;
		seed = 32'h56;
		foreach (rf[i]) rf[i] = '0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		exec(32'hBFFF_FFFF);
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			exec({2'h2, i[3:0], r[25:0]});
		end
		for (int i = 0; i < 32; i++) begin
			r = rnd();
			exec({i[0] ? 8'h00 : 8'h02, i[4:1], r[19:0]});
		end
		for (int i = 0; i < 200; i++) begin
			r = rnd();
			case (r[31:30])
				2'h0: exec({8'h02, r[23:0]});
				2'h1: exec({8'h00, r[23:0]});
				2'h2: exec(r);
				default: exec({8'h7F, r[23:0]});
			endcase
		end
		@(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b0;
		#1;
		chk(32'({instr_ready_o, req, wr_valid_o, wr_index_o}), 32'h40);
		chk(32'(wr_value_o), 32'h0);
		chk(32'(addr), 32'h0);
		repeat (2) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		foreach (rf[i]) rf[i] = '0;
		exec({8'h02, 4'h0, 4'h0, 4'h4, 8'h00, 4'h7});
		exec({8'h00, 4'h0, 4'h0, 4'h5, 8'h00, 4'h3});
		end_sim();
	end
endmodule // testbench
`default_nettype wire
